/* File: dv/dic_src_model.sv */
// peripheral request sources beside the controller
`timescale 1ns/1ps
`default_nettype none
`include "dic_regs.vh"
module dic_src_model (
   // clock
   input wire logic clock_i,
   // wanted levels, one bit per source position
   input wire logic [31:0] want_i,
   // request lines as the peripherals drive them
   output logic [31:0] req_o
);
   // levels held until the bench moves them, far past capture latency
   // one driver only; the design is in reset before the first edge anyway
   always @(posedge clock_i) begin
      req_o <= want_i & `DIC_SRC_MASK;
   end
endmodule // dic_src_model
`default_nettype wire

/* File: dv/dic_top_props.sv */
// port assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "dic_regs.vh"
module dic_top_props (
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_read_i,
   input wire logic [31:0] reg_rdata_o,
   // sources and requests
   input wire logic timer0_req_i,
   input wire logic normal_request_o,
   input wire logic fast_request_o,
   input wire logic [31:0] source_rise_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);
   // read strobe at chosen offsets, ending where the data stand
   sequence s_rd(hit);
      reg_read_i && hit ##1 1'b1;
   endsequence
   // timer request held long enough to reach the raw view
   sequence s_held;
      timer0_req_i [*4];
   endsequence
   a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
      else $error("read data not zero outside an answer");
   a_reset_quiet: assert property (!$past(resetn_i) |-> !normal_request_o && !fast_request_o)
      else $error("request active after reset");
   a_clear_wo: assert property (
      s_rd(reg_addr_i == `DIC_OFS_NRM_CLR || reg_addr_i == `DIC_OFS_FST_CLR) |-> reg_rdata_o == 32'h0)
      else $error("clear register readable");
   a_en_reserved: assert property (
      s_rd(reg_addr_i == `DIC_OFS_NRM_EN || reg_addr_i == `DIC_OFS_FST_EN)
      |-> (reg_rdata_o & ~`DIC_SRC_MASK) == 32'h0)
      else $error("enable mask holds a non-source bit");
   a_swi_fields: assert property (
      s_rd(reg_addr_i == `DIC_OFS_SWI_CFG) |-> (reg_rdata_o & ~`DIC_SWI_MASK) == 32'h0)
      else $error("programmed config holds a stray bit");
   a_bit0_or: assert property (
      s_rd(reg_addr_i == `DIC_OFS_NRM_RAW || reg_addr_i == `DIC_OFS_NRM_STA
      || reg_addr_i == `DIC_OFS_FST_RAW || reg_addr_i == `DIC_OFS_FST_STA)
      |-> reg_rdata_o[0] == |reg_rdata_o[31:1])
      else $error("bit zero is not the OR of the rest");
   a_raw_follows: assert property (
      s_held ##0 s_rd(reg_addr_i == `DIC_OFS_NRM_RAW) |-> reg_rdata_o[2] && reg_rdata_o[0])
      else $error("held timer request missing from raw view");
   a_rise_cause: assert property (
      source_rise_o[2] && $past(resetn_i, 3) |-> $past(timer0_req_i, 2) && !$past(timer0_req_i, 3))
      else $error("timer rise pulse without a timer rise");
endmodule // dic_top_props
bind dic_top dic_top_props i_props (
   .clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_read_i(reg_read_i),
   .reg_rdata_o(reg_rdata_o), .timer0_req_i(timer0_req_i), .normal_request_o(normal_request_o),
   .fast_request_o(fast_request_o), .source_rise_o(source_rise_o)
);
`default_nettype wire

/* File: dv/test_dic_top.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "dic_regs.vh"
module test_dic_top;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_write_i = 1'b0;
   logic reg_read_i = 1'b0;
   logic [31:0] want = 32'h0;
   logic [31:0] src = 32'h0;
   logic [31:0] en_n = 32'h0;
   logic [31:0] en_f = 32'h0;
   logic [31:0] software_interrupt = 32'h0;
   logic [31:0] d;
   logic [7:0] ofs [0:7];
   wire [31:0] req;
   wire [31:0] rise;
   integer n_rise_exp = 0;
   integer n_rise_seen = 0;
   wire [31:0] reg_rdata_o;
   wire normal_request_o;
   wire fast_request_o;
   integer seed = 32'habbc30c9;
   integer n_fail = 0;
   integer n_compared = 0;
   integer t;
   always #2 clock_i = ~clock_i;
   dic_src_model i_src (.clock_i(clock_i), .want_i(want), .req_o(req));
   dic_top i_dut (
      .clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
      .timer0_req_i(req[2]), .timer1_req_i(req[3]), .timer2_req_i(req[4]), .timer3_req_i(req[5]),
      .lin_req_i(req[7]), .flash_req_i(req[8]), .pll_lock_req_i(req[9]), .adc_req_i(req[10]),
      .uart_req_i(req[11]), .spi_req_i(req[12]), .external_pin_request_0_i(req[13]),
      .external_pin_request_1_i(req[14]), .high_voltage_req_i(req[16]),
      .external_pin_request_4_i(req[17]), .external_pin_request_5_i(req[18]),
      .normal_request_o(normal_request_o), .fast_request_o(fast_request_o), .source_rise_o(rise)
   );
   // rise pulses stand one cycle, so each is counted once at a falling edge
   always @(negedge clock_i) begin
      n_rise_seen = n_rise_seen + $countones(rise);
   end
   // bit zero mirrors the OR of the upper bits
   function automatic logic [31:0] fold(input logic [31:0] v);
      fold = {v[31:1], |v[31:1]};
   endfunction
   // expected register view from the bench's own state
   function automatic logic [31:0] model(input logic [7:0] a);
      case (a)
         `DIC_OFS_NRM_RAW: model = fold(src | software_interrupt & 32'h2);
         `DIC_OFS_NRM_EN: model = en_n;
         `DIC_OFS_NRM_STA: model = fold(src & en_n | software_interrupt & 32'h2);
         `DIC_OFS_FST_RAW: model = fold(src | software_interrupt >> 1 & 32'h2);
         `DIC_OFS_FST_EN: model = en_f;
         `DIC_OFS_FST_STA: model = fold(src & en_f | software_interrupt >> 1 & 32'h2);
         `DIC_OFS_SWI_CFG: model = software_interrupt;
         default: model = 32'h0;
      endcase
   endfunction
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one write cycle, then the model follows it
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] m;
      m = v & `DIC_SRC_MASK;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
      case (a)
         `DIC_OFS_NRM_EN: begin
            en_n = en_n | m;
            en_f = en_f & ~m;
         end
         `DIC_OFS_FST_EN: begin
            en_f = en_f | m;
            en_n = en_n & ~m;
         end
         `DIC_OFS_NRM_CLR: en_n = en_n & ~m;
         `DIC_OFS_FST_CLR: en_f = en_f & ~m;
         `DIC_OFS_SWI_CFG: software_interrupt = v & `DIC_SWI_MASK;
         default: ;
      endcase
   endtask
   // one read cycle; data are looked at in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      @(negedge clock_i);
      cmp($sformatf("reg %h", a), model(a), reg_rdata_o);
      @(posedge clock_i);
   endtask
   // settle, then both requests and every offset including one unmapped
   task automatic check_all;
      integer k;
      repeat (5) @(posedge clock_i);
      @(negedge clock_i);
      cmp("normal request", {31'h0, |model(`DIC_OFS_NRM_STA)}, {31'h0, normal_request_o});
      cmp("fast request", {31'h0, |(model(`DIC_OFS_FST_STA) >> 1)}, {31'h0, fast_request_o});
      @(posedge clock_i);
      for (k = 0; k < 10; k = k + 1) rd({k[5:0], 2'b00});
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // main sequence: reset, random register and source traffic, both masks off
   initial begin
      ofs = '{`DIC_OFS_NRM_EN, `DIC_OFS_FST_EN, `DIC_OFS_NRM_CLR, `DIC_OFS_FST_CLR,
              `DIC_OFS_SWI_CFG, `DIC_OFS_NRM_RAW, `DIC_OFS_FST_STA, `DIC_OFS_SWI_CFG};
      repeat (20) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      check_all;
      $display("reset test done");
      for (t = 0; t < 40; t = t + 1) begin
         d = $random(seed) & `DIC_SRC_MASK;
         n_rise_exp = n_rise_exp + $countones(d & ~src);
         src = d;
         want <= src;
         // pins need two more edges before raw and status show them
         repeat (5) @(posedge clock_i);
         d = $random(seed);
         wr(ofs[d[2:0]], $random(seed) & (`DIC_SRC_MASK | 32'h2));
         rd(ofs[d[2:0]]);
         check_all;
         $display("random test %0d done", t);
      end
      wr(`DIC_OFS_NRM_CLR, `DIC_SRC_MASK);
      @(posedge clock_i);
      wr(`DIC_OFS_FST_CLR, `DIC_SRC_MASK);
      check_all;
      $display("both masks off test done");
      // configure, then reset in mid-run: masks and programmed bits must drop
      wr(`DIC_OFS_FST_EN, `DIC_SRC_MASK);
      rd(`DIC_OFS_FST_EN);
      wr(`DIC_OFS_SWI_CFG, `DIC_SWI_MASK);
      resetn_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      en_n = 32'h0;
      en_f = 32'h0;
      software_interrupt = 32'h0;
      n_rise_exp = n_rise_exp + $countones(src);
      check_all;
      $display("mid-run reset test done");
      cmp("rise pulses", n_rise_exp, n_rise_seen);
      wrap_up;
   end
   // watchdog well past the expected run length
   initial begin
      #40000;
      n_fail = n_fail + 1;
      wrap_up;
   end
endmodule // test_dic_top
`default_nettype wire

/* File: include/dic_regs.vh */
// register map, field positions and reset values of the dual level interrupt controller
`ifndef DIC_REGS_VH
`define DIC_REGS_VH

// register byte offsets on the plain register port
`define DIC_ADDR_W 8
`define DIC_OFS_NRM_RAW 8'h00
`define DIC_OFS_NRM_EN 8'h04
`define DIC_OFS_NRM_CLR 8'h08
`define DIC_OFS_NRM_STA 8'h0c
`define DIC_OFS_FST_RAW 8'h10
`define DIC_OFS_FST_EN 8'h14
`define DIC_OFS_FST_CLR 8'h18
`define DIC_OFS_FST_STA 8'h1c
`define DIC_OFS_SWI_CFG 8'h20

// data width and reset values
`define DIC_DATA_W 32
`define DIC_RST_WORD 32'h00000000
`define DIC_RST_BIT 1'h0

// shared bit positions of every register of both levels
`define DIC_BIT_ANY 0
`define DIC_BIT_SWI 1
`define DIC_BIT_TMR0 2
`define DIC_BIT_TMR1 3
`define DIC_BIT_TMR2 4
`define DIC_BIT_TMR3 5
`define DIC_BIT_LIN 7
`define DIC_BIT_FLASH 8
`define DIC_BIT_PLL 9
`define DIC_BIT_ADC 10
`define DIC_BIT_UART 11
`define DIC_BIT_SPI 12
`define DIC_BIT_EXTERNAL_PIN_REQUEST_0 13
`define DIC_BIT_XIRQ1 14
`define DIC_BIT_HV 16
`define DIC_BIT_XIRQ4 17
`define DIC_BIT_XIRQ5 18

// positions that hold a real source: 2-5, 7-14, 16-18
`define DIC_SRC_MASK 32'h00077fbc

// programmed interrupt configuration fields
`define DIC_SWI_NRM 1
`define DIC_SWI_FST 2
`define DIC_SWI_MASK 32'h00000006

`endif

/* File: rtl/dic_level.v */
// one request level: enable mask, raw and masked status, request output
`timescale 1ns/1ps
`default_nettype none
`include "dic_regs.vh"

module dic_level #(
   parameter W = 32,
   parameter OR_LSB = 0
) (
   // clock and reset
   input wire clock_i,
   input wire resetn_i,
   // captured peripheral requests and programmed request
   input wire [W-1:0] src_i,
   input wire swi_i,
   // mask updates: own set, own clear, set seen on the other level
   input wire [W-1:0] set_i,
   input wire [W-1:0] clr_i,
   input wire [W-1:0] xset_i,
   // register views and request
   output reg [W-1:0] en_o,
   output reg [W-1:0] raw_o,
   output reg [W-1:0] sta_o,
   output reg req_o
);

   reg [W-1:0] en_d;

   // set wins over own clear and other-level set; strobes never coincide on one level
   always @* begin
      en_d = (en_o & ~clr_i & ~xset_i) | set_i;
      en_d = en_d & `DIC_SRC_MASK;
   end

   // masks start cleared so no request leaves before setup
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         en_o <= `DIC_RST_WORD;
      end else begin
         en_o <= en_d;
      end
   end

   // raw and status views, programmed bit bypasses the mask
   always @* begin
      raw_o = src_i & `DIC_SRC_MASK;
      raw_o[`DIC_BIT_SWI] = swi_i;
      raw_o[`DIC_BIT_ANY] = |raw_o[W-1:1];
      sta_o = raw_o & en_o;
      sta_o[`DIC_BIT_SWI] = swi_i;
      sta_o[`DIC_BIT_ANY] = |sta_o[W-1:1];
   end

   // plain or of status, no priority, no vector
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         req_o <= `DIC_RST_BIT;
      end else begin
         req_o <= |sta_o[W-1:OR_LSB];
      end
   end

endmodule // dic_level
`default_nettype wire

/* File: rtl/dic_sync.v */
// two flop synchroniser for request pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
`include "dic_regs.vh"

module dic_sync #(
   parameter W = 5
) (
   // clock and reset
   input wire clock_i,
   input wire resetn_i,
   // asynchronous levels in, synchronised levels out
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage is read only by the second stage
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         meta_q <= {W{`DIC_RST_BIT}};
         sync_q <= {W{`DIC_RST_BIT}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // dic_sync
`default_nettype wire

/* File: rtl/dic_top.v */
// dual level interrupt controller: source capture, registers, normal and fast requests
`timescale 1ns/1ps
`default_nettype none
`include "dic_regs.vh"

module dic_top #(
   parameter DW = `DIC_DATA_W,
   parameter AW = `DIC_ADDR_W,
   parameter NPIN = 5
) (
   // clock and reset
   input wire clock_i,
   input wire resetn_i,
   // register port
   input wire [AW-1:0] reg_addr_i,
   input wire [DW-1:0] reg_wdata_i,
   input wire reg_write_i,
   input wire reg_read_i,
   output wire [DW-1:0] reg_rdata_o,
   // on-chip peripheral requests, same clock
   input wire timer0_req_i,
   input wire timer1_req_i,
   input wire timer2_req_i,
   input wire timer3_req_i,
   input wire lin_req_i,
   input wire flash_req_i,
   input wire pll_lock_req_i,
   input wire adc_req_i,
   input wire uart_req_i,
   input wire spi_req_i,
   // pin driven requests, asynchronous
   input wire external_pin_request_0_i,
   input wire external_pin_request_1_i,
   input wire high_voltage_req_i,
   input wire external_pin_request_4_i,
   input wire external_pin_request_5_i,
   // requests to the core
   output wire normal_request_o,
   output wire fast_request_o,
   // start of every assertion of each raw source, for time capture
   output wire [DW-1:0] source_rise_o
);

   // address match on the register port
   function hit;
      input [AW-1:0] addr;
      input [AW-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // keep only the bits that hold a real source
   function [DW-1:0] src_only;
      input [DW-1:0] word;
      begin
         src_only = word & `DIC_SRC_MASK;
      end
   endfunction

   wire [NPIN-1:0] pin_async;
   wire [NPIN-1:0] pin_sync;
   reg [DW-1:0] src_d;
   reg [DW-1:0] src_q;
   reg [DW-1:0] raw_prev_q;
   reg [DW-1:0] rise_q;
   reg [DW-1:0] swi_q;
   reg [DW-1:0] rdata_q;
   reg [DW-1:0] rdata_d;
   wire wr_nrm_en;
   wire wr_nrm_clr;
   wire wr_fst_en;
   wire wr_fst_clr;
   wire wr_swi;
   wire [DW-1:0] nrm_set;
   wire [DW-1:0] nrm_clr;
   wire [DW-1:0] fst_set;
   wire [DW-1:0] fst_clr;
   wire [DW-1:0] nrm_en;
   wire [DW-1:0] nrm_raw;
   wire [DW-1:0] nrm_sta;
   wire [DW-1:0] fst_en;
   wire [DW-1:0] fst_raw;
   wire [DW-1:0] fst_sta;
   wire nrm_req;
   wire fst_req;

   // pins come from outside the clock domain
   assign pin_async[0] = external_pin_request_0_i;
   assign pin_async[1] = external_pin_request_1_i;
   assign pin_async[2] = high_voltage_req_i;
   assign pin_async[3] = external_pin_request_4_i;
   assign pin_async[4] = external_pin_request_5_i;

   dic_sync #(
      .W(NPIN)
   ) u_pin_sync (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .async_i(pin_async),
      .sync_o(pin_sync)
   );

   // each source lands on its fixed position
   always @* begin
      src_d = `DIC_RST_WORD;
      src_d[`DIC_BIT_TMR0] = timer0_req_i;
      src_d[`DIC_BIT_TMR1] = timer1_req_i;
      src_d[`DIC_BIT_TMR2] = timer2_req_i;
      src_d[`DIC_BIT_TMR3] = timer3_req_i;
      src_d[`DIC_BIT_LIN] = lin_req_i;
      src_d[`DIC_BIT_FLASH] = flash_req_i;
      src_d[`DIC_BIT_PLL] = pll_lock_req_i;
      src_d[`DIC_BIT_ADC] = adc_req_i;
      src_d[`DIC_BIT_UART] = uart_req_i;
      src_d[`DIC_BIT_SPI] = spi_req_i;
      src_d[`DIC_BIT_EXTERNAL_PIN_REQUEST_0] = pin_sync[0];
      src_d[`DIC_BIT_XIRQ1] = pin_sync[1];
      src_d[`DIC_BIT_HV] = pin_sync[2];
      src_d[`DIC_BIT_XIRQ4] = pin_sync[3];
      src_d[`DIC_BIT_XIRQ5] = pin_sync[4];
   end

   // capture stage: a request shorter than one clock may be missed
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         src_q <= `DIC_RST_WORD;
      end else begin
         src_q <= src_only(src_d);
      end
   end

   // write decode, one strobe per cycle by bus contract
   assign wr_nrm_en = reg_write_i && hit(reg_addr_i, `DIC_OFS_NRM_EN);
   assign wr_nrm_clr = reg_write_i && hit(reg_addr_i, `DIC_OFS_NRM_CLR);
   assign wr_fst_en = reg_write_i && hit(reg_addr_i, `DIC_OFS_FST_EN);
   assign wr_fst_clr = reg_write_i && hit(reg_addr_i, `DIC_OFS_FST_CLR);
   assign wr_swi = reg_write_i && hit(reg_addr_i, `DIC_OFS_SWI_CFG);

   // bits 0, 1 and reserved positions are dropped here
   assign nrm_set = wr_nrm_en ? src_only(reg_wdata_i) : `DIC_RST_WORD;
   assign nrm_clr = wr_nrm_clr ? src_only(reg_wdata_i) : `DIC_RST_WORD;
   assign fst_set = wr_fst_en ? src_only(reg_wdata_i) : `DIC_RST_WORD;
   assign fst_clr = wr_fst_clr ? src_only(reg_wdata_i) : `DIC_RST_WORD;

   // programmed interrupt configuration, only its two fields are kept
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         swi_q <= `DIC_RST_WORD;
      end else if (wr_swi) begin
         swi_q <= reg_wdata_i & `DIC_SWI_MASK;
      end
   end

   // normal level; a fast enable set knocks the bit out here
   dic_level #(
      .W(DW),
      .OR_LSB(0)
   ) u_normal (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .src_i(src_q),
      .swi_i(swi_q[`DIC_SWI_NRM]),
      .set_i(nrm_set),
      .clr_i(nrm_clr),
      .xset_i(fst_set),
      .en_o(nrm_en),
      .raw_o(nrm_raw),
      .sta_o(nrm_sta),
      .req_o(nrm_req)
   );

   // fast level, same structure, or taken over bits 31:1
   dic_level #(
      .W(DW),
      .OR_LSB(1)
   ) u_fast (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .src_i(src_q),
      .swi_i(swi_q[`DIC_SWI_FST]),
      .set_i(fst_set),
      .clr_i(fst_clr),
      .xset_i(nrm_set),
      .en_o(fst_en),
      .raw_o(fst_raw),
      .sta_o(fst_sta),
      .req_o(fst_req)
   );

   // requests ignore the core's own disable bits
   assign normal_request_o = nrm_req;
   assign fast_request_o = fst_req;

   // rising edge of raw sources, one cycle pulse
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         raw_prev_q <= `DIC_RST_WORD;
         rise_q <= `DIC_RST_WORD;
      end else begin
         raw_prev_q <= src_q;
         rise_q <= src_q & ~raw_prev_q;
      end
   end

   assign source_rise_o = rise_q;

   // read mux; clear registers and unmapped offsets read zero
   always @* begin
      rdata_d = `DIC_RST_WORD;
      if (hit(reg_addr_i, `DIC_OFS_NRM_RAW)) begin
         rdata_d = nrm_raw;
      end else if (hit(reg_addr_i, `DIC_OFS_NRM_EN)) begin
         rdata_d = nrm_en;
      end else if (hit(reg_addr_i, `DIC_OFS_NRM_STA)) begin
         rdata_d = nrm_sta;
      end else if (hit(reg_addr_i, `DIC_OFS_FST_RAW)) begin
         rdata_d = fst_raw;
      end else if (hit(reg_addr_i, `DIC_OFS_FST_EN)) begin
         rdata_d = fst_en;
      end else if (hit(reg_addr_i, `DIC_OFS_FST_STA)) begin
         rdata_d = fst_sta;
      end else if (hit(reg_addr_i, `DIC_OFS_SWI_CFG)) begin
         rdata_d = swi_q;
      end
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         rdata_q <= `DIC_RST_WORD;
      end else if (reg_read_i) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= `DIC_RST_WORD;
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule // dic_top
`default_nettype wire
